//--- src/oma_adapter.v
// Functional notes
// - Detect end of each packet written to tx queue; pulse bumps written-packet total.
// - Store only bit 3 of the last-word unused-byte indicator in the queue.
// - Carry written-packet total over to the MAC transmit side.
// - Pending packets = written total minus read total; forward when at least one.
// - Leave idle for claim only with pending nonzero and tx queue not empty.
// - Claim lasts one cycle, decrements pending, pulses read strobe; show-ahead data.
// - Next cycle enter transfer, first word out with first flag and valid high.
// - Outgoing word loads from queue data on read strobe, holds otherwise.
// - After MAC ready takes the first word, drop the first flag.
// - Decrement remaining-data counter when the start word is sent.
// - In transfer, read strobe follows MAC ready, except after the last word or while the tx queue is empty.
// - After last word with valid is sent, go idle and drop valid.
// - New rx packet with rx enabled and fill level below 224 is stored, entering transfer unless it is one word.
// - Rx queue write strobe and word are the store decision and MAC word delayed one cycle.
// - In rx transfer, valid with last flag returns to idle.
// - New rx packet with fill level 224 or more enters discard, or stays idle if it is one word.
// - In discard, hold write strobe low until valid last word, then idle.
// - One clock, SYS_CLK_I, shared by the engine, MAC transmit and MAC receive sides.
// - Each queue is 512 entries of 258 bits.
`timescale 1ns/1ps
`include "oma_defines.vh"

module oma_adapter #(
  parameter DW    = `OMA_DATA_W,
  parameter QW    = `OMA_QUEUE_W,
  parameter DEPTH = `OMA_QUEUE_DEPTH,
  parameter AW    = `OMA_QUEUE_AW
) (
  input  wire                     SYS_CLK_I,
  input  wire                     RST_B_I,
  // APB register port
  input  wire                     PSEL_I,
  input  wire                     PENABLE_I,
  input  wire                     PWRITE_I,
  input  wire [`OMA_ADDR_W-1:0]   PADDR_I,
  input  wire [31:0]              PWDATA_I,
  output reg  [31:0]              PRDATA_O,
  output reg                      PREADY_O,
  output reg                      PSLVERR_O,
  // Engine transmit write port
  input  wire                     TX_WR_EN_I,
  input  wire [DW-1:0]            TX_WR_WORD_I,
  input  wire                     TX_WR_LAST_I,
  input  wire [`OMA_UNUSED_W-1:0] TX_END_UNUSED_BYTES_I,
  output reg                      TX_FULL_O,
  // MAC transmit stream
  output reg  [DW-1:0]            MAC_TX_WORD_O,
  output reg                      MAC_TX_VALID_O,
  output reg                      MAC_TX_FIRST_FLAG_O,
  output reg                      MAC_TX_LAST_FLAG_O,
  output reg  [`OMA_UNUSED_W-1:0] MAC_TX_UNUSED_BYTES_O,
  input  wire                     MAC_TX_READY_I,
  // MAC receive stream
  input  wire                     MAC_RX_VALID_I,
  input  wire [DW-1:0]            MAC_RX_WORD_I,
  input  wire                     MAC_RX_LAST_FLAG_I,
  input  wire [`OMA_UNUSED_W-1:0] MAC_RX_UNUSED_BYTES_I,
  // Engine receive read port
  input  wire                     RX_RD_EN_I,
  output wire [DW-1:0]            RX_RD_WORD_O,
  output wire                     RX_RD_LAST_O,
  output wire [`OMA_UNUSED_W-1:0] RX_RD_UNUSED_BYTES_O,
  output wire                     RX_EMPTY_O
);

  // Tx and rx states
  localparam [1:0] IDLE_STATE     = 2'h0;
  localparam [1:0] CLAIM_PACKET_STATE = 2'h1;
  localparam [1:0] TRANSFER_STATE = 2'h2;
  localparam [1:0] DISCARD_STATE  = 2'h3;

  reg  [1:0]        ctrl_r;
  reg  [1:0]        tx_state_reg;
  reg  [1:0]        tx_state_nxt;
  reg  [1:0]        rx_state_r;
  reg  [1:0]        rx_state_nxt;
  reg               tx_end_pulse_r;
  reg  [31:0]       written_packet_total;
  reg  [31:0]       written_copy_r;
  reg  [31:0]       read_packet_total;
  reg  [`OMA_CNT_W-1:0] pending_packet_count;
  reg  [31:0]       tx_frames_left_r;
  reg  [31:0]       tx_sent_r;
  reg               txq_read_strobe;
  reg               rxq_write_strobe;
  reg  [QW-1:0]     rxq_write_word;
  reg               rx_store;
  reg  [31:0]       rx_drop_r;
  reg  [31:0]       rx_taken_r;
  reg  [31:0]       rd_mux;
  reg               rd_hit;
  wire              txq_is_empty;
  wire              txq_full;
  wire [QW-1:0]     txq_read_word;
  wire [AW:0]       txq_count;
  wire              txq_wr;
  wire [AW:0]       rxq_fill_level;
  wire [QW-1:0]     rxq_read_word;
  wire              rx_fits;
  wire              tx_take;
  wire              apb_write;

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: answer with no wait state, ready raised during the access phase

  assign apb_write = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;

  // Read mux with unmapped detection
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (PADDR_I)
      `OMA_REG_CTRL: begin
        rd_mux[1:0] = ctrl_r;
      end
      `OMA_REG_STATUS: begin
        rd_mux[`OMA_ST_TX_LSB+1:`OMA_ST_TX_LSB] = tx_state_reg;
        rd_mux[`OMA_ST_RX_LSB+1:`OMA_ST_RX_LSB] = rx_state_r;
        rd_mux[`OMA_ST_PEND_LSB+`OMA_CNT_W-1:`OMA_ST_PEND_LSB] = pending_packet_count;
        rd_mux[`OMA_ST_FILL_LSB+AW:`OMA_ST_FILL_LSB] = rxq_fill_level;
        rd_mux[`OMA_ST_LEFT_LSB+5:`OMA_ST_LEFT_LSB] = tx_frames_left_r[5:0];
      end
      `OMA_REG_TX_SENT: begin
        rd_mux = tx_sent_r;
      end
      `OMA_REG_RX_DROP: begin
        rd_mux = rx_drop_r;
      end
      `OMA_REG_RX_TAKEN: begin
        rd_mux = rx_taken_r;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Ready, read data and error all settle at the setup edge
  always @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
      ctrl_r    <= `OMA_CTRL_RST;
    end else begin
      PREADY_O <= PSEL_I & ~PENABLE_I;
      if (PSEL_I && !PENABLE_I) begin
        PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : rd_mux;
        PSLVERR_O <= ~rd_hit;
      end else if (PREADY_O) begin
        PSLVERR_O <= 1'b0;
      end
      // Only the control word is writable; others ignore writes
      if (apb_write && PADDR_I == `OMA_REG_CTRL) begin
        ctrl_r <= PWDATA_I[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit write side

  // All three sides share SYS_CLK_I in this build, so the crossings reduce to register stages
  assign txq_wr = TX_WR_EN_I & ~txq_full;

  // Tx queue, 512 x 258
  oma_queue #(
    .WIDTH (QW),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_tx_queue (
    .clk_i     (SYS_CLK_I),
    .rst_b_i   (RST_B_I),
    .wr_en_i   (txq_wr),
    .wr_data_i ({TX_END_UNUSED_BYTES_I[`OMA_UNUSED_SEL], TX_WR_LAST_I, TX_WR_WORD_I}),
    .full_o    (txq_full),
    .rd_en_i   (txq_read_strobe),
    .rd_data_o (txq_read_word),
    .empty_o   (txq_is_empty),
    .count_o   (txq_count)
  );

  // End-of-packet pulse and packet total; copy stage stands for the crossing
  always @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      tx_end_pulse_r       <= 1'b0;
      written_packet_total <= 32'h0000_0000;
      written_copy_r       <= 32'h0000_0000;
      TX_FULL_O            <= 1'b0;
    end else begin
      tx_end_pulse_r <= txq_wr & TX_WR_LAST_I;
      if (tx_end_pulse_r) begin
        written_packet_total <= written_packet_total + 1'b1;
      end
      written_copy_r <= written_packet_total;
      // Full early by one so a write in flight is not lost
      TX_FULL_O <= (txq_count >= DEPTH[AW:0] - 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit state machine

  assign tx_take = MAC_TX_VALID_O & MAC_TX_READY_I;

  // Next state and read strobe
  always @* begin
    tx_state_nxt    = tx_state_reg;
    txq_read_strobe = 1'b0;
    case (tx_state_reg)
      IDLE_STATE: begin
        if (ctrl_r[`OMA_CTRL_TX_EN] && pending_packet_count != {`OMA_CNT_W{1'b0}}
            && !txq_is_empty) begin
          tx_state_nxt = CLAIM_PACKET_STATE;
        end
      end
      CLAIM_PACKET_STATE: begin
        txq_read_strobe = 1'b1;
        tx_state_nxt    = TRANSFER_STATE;
      end
      TRANSFER_STATE: begin
        // No read past the last word of the packet
        txq_read_strobe = MAC_TX_READY_I & ~MAC_TX_LAST_FLAG_O & ~txq_is_empty;
        if (tx_take && MAC_TX_LAST_FLAG_O) begin
          tx_state_nxt = IDLE_STATE;
        end
      end
      default: begin
        tx_state_nxt = IDLE_STATE;
      end
    endcase
  end

  // Packet accounting on the MAC side
  always @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      tx_state_reg         <= IDLE_STATE;
      read_packet_total    <= 32'h0000_0000;
      pending_packet_count <= {`OMA_CNT_W{1'b0}};
      tx_frames_left_r     <= 32'h0000_0000;
      tx_sent_r            <= 32'h0000_0000;
    end else begin
      tx_state_reg <= tx_state_nxt;
      if (tx_state_reg == CLAIM_PACKET_STATE) begin
        read_packet_total    <= read_packet_total + 1'b1;
        pending_packet_count <= written_copy_r[`OMA_CNT_W-1:0]
                                - read_packet_total[`OMA_CNT_W-1:0] - 1'b1;
      end else begin
        pending_packet_count <= written_copy_r[`OMA_CNT_W-1:0]
                                - read_packet_total[`OMA_CNT_W-1:0];
      end
      // Frames still owed to the MAC drop as each start word goes out
      if (tx_end_pulse_r && !(tx_take && MAC_TX_FIRST_FLAG_O)) begin
        tx_frames_left_r <= tx_frames_left_r + 1'b1;
      end else if (!tx_end_pulse_r && tx_take && MAC_TX_FIRST_FLAG_O) begin
        tx_frames_left_r <= tx_frames_left_r - 1'b1;
      end
      if (tx_take && MAC_TX_LAST_FLAG_O) begin
        tx_sent_r <= tx_sent_r + 1'b1;
      end
    end
  end

  // Outgoing stream registers
  always @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      MAC_TX_WORD_O         <= {DW{1'b0}};
      MAC_TX_VALID_O        <= 1'b0;
      MAC_TX_FIRST_FLAG_O   <= 1'b0;
      MAC_TX_LAST_FLAG_O    <= 1'b0;
      MAC_TX_UNUSED_BYTES_O <= `OMA_UNUSED_LO;
    end else begin
      // Word and its tags change only on a read strobe
      if (txq_read_strobe) begin
        MAC_TX_WORD_O         <= txq_read_word[DW-1:0];
        MAC_TX_LAST_FLAG_O    <= txq_read_word[`OMA_Q_LAST_BIT];
        MAC_TX_UNUSED_BYTES_O <= txq_read_word[`OMA_Q_UNUSED_BIT] ? `OMA_UNUSED_HI : `OMA_UNUSED_LO;
      end
      if (tx_state_reg == CLAIM_PACKET_STATE) begin
        MAC_TX_VALID_O      <= 1'b1;
        MAC_TX_FIRST_FLAG_O <= 1'b1;
      end else begin
        if (tx_take) begin
          MAC_TX_FIRST_FLAG_O <= 1'b0;
        end
        if (tx_take && MAC_TX_LAST_FLAG_O) begin
          MAC_TX_VALID_O <= 1'b0;
        end else if (tx_take && !txq_read_strobe) begin
          MAC_TX_VALID_O <= 1'b0; // Underrun guard, queue ran dry mid packet
        end else if (txq_read_strobe) begin
          MAC_TX_VALID_O <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive state machine

  // Fill level seen at the first word; rx disable forces discard
  assign rx_fits = ctrl_r[`OMA_CTRL_RX_EN] && (rxq_fill_level < `OMA_RX_FILL_LIMIT);

  // Next state and store decision
  always @* begin
    rx_state_nxt = rx_state_r;
    rx_store     = 1'b0;
    case (rx_state_r)
      IDLE_STATE: begin
        if (MAC_RX_VALID_I) begin
          if (rx_fits) begin
            rx_store = 1'b1;
            if (!MAC_RX_LAST_FLAG_I) begin
              rx_state_nxt = TRANSFER_STATE;
            end
          end else if (!MAC_RX_LAST_FLAG_I) begin
            rx_state_nxt = DISCARD_STATE;
          end
        end
      end
      TRANSFER_STATE: begin
        rx_store = MAC_RX_VALID_I;
        if (MAC_RX_VALID_I && MAC_RX_LAST_FLAG_I) begin
          rx_state_nxt = IDLE_STATE;
        end
      end
      DISCARD_STATE: begin
        rx_store = 1'b0;
        if (MAC_RX_VALID_I && MAC_RX_LAST_FLAG_I) begin
          rx_state_nxt = IDLE_STATE;
        end
      end
      default: begin
        rx_state_nxt = IDLE_STATE;
      end
    endcase
  end

  // One-cycle delayed write port and packet counters
  always @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      rx_state_r       <= IDLE_STATE;
      rxq_write_strobe <= 1'b0;
      rxq_write_word   <= {QW{1'b0}};
      rx_drop_r        <= 32'h0000_0000;
      rx_taken_r       <= 32'h0000_0000;
    end else begin
      rx_state_r       <= rx_state_nxt;
      rxq_write_strobe <= rx_store;
      rxq_write_word   <= {MAC_RX_UNUSED_BYTES_I[`OMA_UNUSED_SEL], MAC_RX_LAST_FLAG_I, MAC_RX_WORD_I};
      if (rx_state_r == IDLE_STATE && MAC_RX_VALID_I) begin
        if (rx_fits) begin
          rx_taken_r <= rx_taken_r + 1'b1;
        end else begin
          rx_drop_r <= rx_drop_r + 1'b1;
        end
      end
    end
  end

  // Rx queue, 512 x 258
  oma_queue #(
    .WIDTH (QW),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_rx_queue (
    .clk_i     (SYS_CLK_I),
    .rst_b_i   (RST_B_I),
    .wr_en_i   (rxq_write_strobe),
    .wr_data_i (rxq_write_word),
    .full_o    (),
    .rd_en_i   (RX_RD_EN_I),
    .rd_data_o (rxq_read_word),
    .empty_o   (RX_EMPTY_O),
    .count_o   (rxq_fill_level)
  );

  // Show-ahead read port toward the engine
  assign RX_RD_WORD_O         = rxq_read_word[DW-1:0];
  assign RX_RD_LAST_O         = rxq_read_word[`OMA_Q_LAST_BIT];
  assign RX_RD_UNUSED_BYTES_O = rxq_read_word[`OMA_Q_UNUSED_BIT] ? `OMA_UNUSED_HI : `OMA_UNUSED_LO;

endmodule // oma_adapter

//--- common/oma_defines.vh
`ifndef OMA_DEFINES_VH
`define OMA_DEFINES_VH

// Datapath and queue shape
`define OMA_DATA_W        256
`define OMA_QUEUE_W       258
`define OMA_QUEUE_DEPTH   512
`define OMA_QUEUE_AW      9
`define OMA_CNT_W         10
`define OMA_UNUSED_W      5

// Queue word layout
`define OMA_Q_LAST_BIT    256
`define OMA_Q_UNUSED_BIT  257
`define OMA_UNUSED_SEL    3
`define OMA_UNUSED_HI     5'h0a
`define OMA_UNUSED_LO     5'h04

// Receive admission threshold on the queue fill level
`define OMA_RX_FILL_LIMIT 10'h0e0

// Register byte addresses
`define OMA_ADDR_W        12
`define OMA_REG_CTRL      12'h000
`define OMA_REG_STATUS    12'h004
`define OMA_REG_TX_SENT   12'h008
`define OMA_REG_RX_DROP   12'h00c
`define OMA_REG_RX_TAKEN  12'h010

// Control fields and reset value
`define OMA_CTRL_TX_EN    0
`define OMA_CTRL_RX_EN    1
`define OMA_CTRL_RST      2'h3

// Status field positions
`define OMA_ST_TX_LSB     0
`define OMA_ST_RX_LSB     2
`define OMA_ST_PEND_LSB   4
`define OMA_ST_FILL_LSB   16
`define OMA_ST_LEFT_LSB   26

`endif

//--- src/oma_queue.v
`timescale 1ns/1ps
`include "oma_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Show-ahead queue in flip-flops; read data is valid while not empty
module oma_queue #(
  parameter WIDTH = `OMA_QUEUE_W,
  parameter DEPTH = `OMA_QUEUE_DEPTH,
  parameter AW    = `OMA_QUEUE_AW
) (
  input  wire             clk_i,
  input  wire             rst_b_i,
  input  wire             wr_en_i,
  input  wire [WIDTH-1:0] wr_data_i,
  output wire             full_o,
  input  wire             rd_en_i,
  output wire [WIDTH-1:0] rd_data_o,
  output wire             empty_o,
  output wire [AW:0]      count_o
);

  reg  [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_r;
  reg  [AW-1:0]    rd_ptr_r;
  reg  [AW:0]      count_r;
  wire             do_wr;
  wire             do_rd;

  // Refuse writes when full and reads when empty
  assign do_wr     = wr_en_i & ~full_o;
  assign do_rd     = rd_en_i & ~empty_o;
  assign full_o    = (count_r == DEPTH[AW:0]);
  assign empty_o   = (count_r == {(AW+1){1'b0}});
  assign count_o   = count_r;
  assign rd_data_o = mem_r[rd_ptr_r];

  // Storage has no reset; only pointers matter
  always @(posedge clk_i) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= wr_data_i;
    end
  end

  // Pointers and occupancy
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_r <= count_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule // oma_queue

//--- sim/oma_adapter_chk.sv
`timescale 1ns/1ps
`include "oma_defines.vh"

module oma_adapter_chk #(
  parameter DW = `OMA_DATA_W
) (
  input wire logic                     SYS_CLK_I,
  input wire logic                     RST_B_I,
  input wire logic                     PSEL_I,
  input wire logic                     PENABLE_I,
  input wire logic                     PREADY_O,
  input wire logic                     TX_WR_EN_I,
  input wire logic                     TX_WR_LAST_I,
  input wire logic                     TX_FULL_O,
  input wire logic [DW-1:0]            MAC_TX_WORD_O,
  input wire logic                     MAC_TX_VALID_O,
  input wire logic                     MAC_TX_FIRST_FLAG_O,
  input wire logic                     MAC_TX_LAST_FLAG_O,
  input wire logic [`OMA_UNUSED_W-1:0] MAC_TX_UNUSED_BYTES_O,
  input wire logic                     MAC_TX_READY_I,
  input wire logic                     MAC_RX_VALID_I,
  input wire logic                     RX_EMPTY_O
);
  logic [15:0] wr_pkts_r;
  logic [15:0] tx_pkts_r;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_B_I);

  ////////////////////////////////////////////////////////////////////////////
  // Packets written versus packets sent, to judge when a send may start
  always @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      wr_pkts_r <= 16'h0000;
      tx_pkts_r <= 16'h0000;
    end else begin
      wr_pkts_r <= wr_pkts_r + {15'h0000, TX_WR_EN_I & TX_WR_LAST_I & ~TX_FULL_O};
      tx_pkts_r <= tx_pkts_r + {15'h0000, MAC_TX_VALID_O & MAC_TX_READY_I & MAC_TX_LAST_FLAG_O};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stream steps
  sequence s_tx_take;
    MAC_TX_VALID_O && MAC_TX_READY_I;
  endsequence
  sequence s_tx_end;
    s_tx_take ##0 MAC_TX_LAST_FLAG_O;
  endsequence

  property p_tx_gap;
    s_tx_end |=> !MAC_TX_VALID_O [*2];
  endproperty
  property p_first_drop;
    s_tx_take ##0 MAC_TX_FIRST_FLAG_O |=> !MAC_TX_FIRST_FLAG_O;
  endproperty
  property p_tx_hold;
    MAC_TX_VALID_O && !MAC_TX_READY_I |=> MAC_TX_VALID_O && $stable(MAC_TX_WORD_O) && $stable(MAC_TX_FIRST_FLAG_O);
  endproperty
  property p_tx_sop;
    $rose(MAC_TX_VALID_O) |-> MAC_TX_FIRST_FLAG_O;
  endproperty
  property p_tx_pending;
    $rose(MAC_TX_VALID_O) |-> wr_pkts_r != tx_pkts_r;
  endproperty
  property p_tx_launch;
    (wr_pkts_r != tx_pkts_r) && !MAC_TX_VALID_O |-> ##[1:8] MAC_TX_VALID_O;
  endproperty
  property p_tx_unused;
    s_tx_end |-> MAC_TX_UNUSED_BYTES_O inside {5'h04, 5'h0a};
  endproperty
  property p_rx_delay;
    $fell(RX_EMPTY_O) |-> $past(MAC_RX_VALID_I, 2);
  endproperty
  property p_apb_ready;
    PSEL_I && !PENABLE_I |=> PREADY_O;
  endproperty

  a_tx_gap: assert property (p_tx_gap) else $error("valid not low after last word");
  a_first_drop: assert property (p_first_drop) else $error("first flag kept after take");
  a_tx_hold: assert property (p_tx_hold) else $error("word changed while stalled");
  a_tx_sop: assert property (p_tx_sop) else $error("packet start without first flag");
  a_tx_pending: assert property (p_tx_pending) else $error("send with nothing pending");
  a_tx_launch: assert property (p_tx_launch) else $error("pending packet not started");
  a_tx_unused: assert property (p_tx_unused) else $error("bad unused byte code");
  a_rx_delay: assert property (p_rx_delay) else $error("rx store not one cycle after valid");
  a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
endmodule // oma_adapter_chk

//--- sim/oma_mac_model.sv
`timescale 1ns/1ps

module oma_mac_model #(
  parameter DW = 256
) (
  input wire logic           clk_i,
  input wire logic           slow_i,
  output logic               ready_o,
  output logic               rx_valid_o,
  output logic               rx_last_o,
  output logic [DW-1:0]      rx_word_o,
  output logic [4:0]         rx_unused_o
);
  logic          v_r = 1'b0;
  logic          l_r = 1'b0;
  logic [DW-1:0] w_r = '0;
  logic [31:0]   tick_r = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Ready stalls at random in slow mode; tick scrambles idle lines
  initial ready_o = 1'b0;
  always @(posedge clk_i) begin
    tick_r  <= tick_r + 32'h0000_0001;
    ready_o <= !slow_i || ($urandom_range(2) != 0);
  end

  // Idle lines never keep the last word, so stale data cannot pass
  assign rx_valid_o  = v_r;
  assign rx_word_o   = v_r ? w_r : {(DW/32){tick_r}};
  assign rx_last_o   = v_r ? l_r : tick_r[0];
  assign rx_unused_o = v_r ? (l_r ? 5'h0a : 5'h04) : tick_r[4:0];

  task send(input logic [DW-1:0] w, input logic l);
    @(posedge clk_i);
    v_r <= 1'b1;
    w_r <= w;
    l_r <= l;
  endtask

  // Gap after a packet so the fill level settles before the next one
  task stop();
    @(posedge clk_i);
    v_r <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule // oma_mac_model

//--- sim/oma_adapter_test.sv
`timescale 1ns/1ps
`include "oma_defines.vh"

bind oma_adapter oma_adapter_chk #(.DW(DW)) u_chk (
  .SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O),
  .TX_WR_EN_I(TX_WR_EN_I), .TX_WR_LAST_I(TX_WR_LAST_I), .TX_FULL_O(TX_FULL_O), .MAC_TX_WORD_O(MAC_TX_WORD_O),
  .MAC_TX_VALID_O(MAC_TX_VALID_O), .MAC_TX_FIRST_FLAG_O(MAC_TX_FIRST_FLAG_O), .MAC_TX_LAST_FLAG_O(MAC_TX_LAST_FLAG_O),
  .MAC_TX_UNUSED_BYTES_O(MAC_TX_UNUSED_BYTES_O), .MAC_TX_READY_I(MAC_TX_READY_I), .MAC_RX_VALID_I(MAC_RX_VALID_I),
  .RX_EMPTY_O(RX_EMPTY_O));

module oma_adapter_test;
  localparam DW = `OMA_DATA_W;
  logic                     SYS_CLK_I = 1'b0;
  logic                     RST_B_I, PSEL_I, PENABLE_I, PWRITE_I, TX_WR_EN_I, TX_WR_LAST_I, RX_RD_EN_I, slow;
  logic [`OMA_ADDR_W-1:0]   PADDR_I;
  logic [31:0]              PWDATA_I, PRDATA_O;
  logic                     PREADY_O, PSLVERR_O, TX_FULL_O, RX_RD_LAST_O, RX_EMPTY_O;
  logic [DW-1:0]            TX_WR_WORD_I, MAC_TX_WORD_O, MAC_RX_WORD_I, RX_RD_WORD_O;
  logic                     MAC_TX_VALID_O, MAC_TX_FIRST_FLAG_O, MAC_TX_LAST_FLAG_O;
  logic                     MAC_TX_READY_I, MAC_RX_VALID_I, MAC_RX_LAST_FLAG_I;
  logic [`OMA_UNUSED_W-1:0] TX_END_UNUSED_BYTES_I, MAC_TX_UNUSED_BYTES_O, MAC_RX_UNUSED_BYTES_I, RX_RD_UNUSED_BYTES_O;
  int                       mismatches = 0;
  int                       checks_done = 0;
  logic [262:0]             exp_tx[$];
  logic [262:0]             exp_rx[$];
  logic [32:0]              exp_reg[$];

  oma_adapter dut (.SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .TX_WR_EN_I(TX_WR_EN_I), .TX_WR_WORD_I(TX_WR_WORD_I), .TX_WR_LAST_I(TX_WR_LAST_I),
    .TX_END_UNUSED_BYTES_I(TX_END_UNUSED_BYTES_I), .TX_FULL_O(TX_FULL_O), .MAC_TX_WORD_O(MAC_TX_WORD_O),
    .MAC_TX_VALID_O(MAC_TX_VALID_O), .MAC_TX_FIRST_FLAG_O(MAC_TX_FIRST_FLAG_O),
    .MAC_TX_LAST_FLAG_O(MAC_TX_LAST_FLAG_O), .MAC_TX_UNUSED_BYTES_O(MAC_TX_UNUSED_BYTES_O),
    .MAC_TX_READY_I(MAC_TX_READY_I), .MAC_RX_VALID_I(MAC_RX_VALID_I), .MAC_RX_WORD_I(MAC_RX_WORD_I),
    .MAC_RX_LAST_FLAG_I(MAC_RX_LAST_FLAG_I), .MAC_RX_UNUSED_BYTES_I(MAC_RX_UNUSED_BYTES_I),
    .RX_RD_EN_I(RX_RD_EN_I), .RX_RD_WORD_O(RX_RD_WORD_O), .RX_RD_LAST_O(RX_RD_LAST_O),
    .RX_RD_UNUSED_BYTES_O(RX_RD_UNUSED_BYTES_O), .RX_EMPTY_O(RX_EMPTY_O));

  oma_mac_model #(.DW(DW)) mac (.clk_i(SYS_CLK_I), .slow_i(slow), .ready_o(MAC_TX_READY_I),
    .rx_valid_o(MAC_RX_VALID_I), .rx_last_o(MAC_RX_LAST_FLAG_I), .rx_word_o(MAC_RX_WORD_I),
    .rx_unused_o(MAC_RX_UNUSED_BYTES_I));

  always #25 SYS_CLK_I = ~SYS_CLK_I;

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [262:0] seen, input logic [262:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Register cycle; a read notes its expected error bit and data first
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!wr) exp_reg.push_back(e);
    @(posedge SYS_CLK_I);
    PSEL_I <= 1'b1; PENABLE_I <= 1'b0; PWRITE_I <= wr; PADDR_I <= a; PWDATA_I <= d;
    @(posedge SYS_CLK_I);
    PENABLE_I <= 1'b1;
    do @(posedge SYS_CLK_I); while (!PREADY_O);
    PSEL_I <= 1'b0; PENABLE_I <= 1'b0;
  endtask

  task tx_pkt(input int n, input logic hi);
    logic [DW-1:0] w;
    logic [4:0]    u;
    u = hi ? 5'h0a : 5'h04;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < DW/32; k++) w[k*32 +: 32] = $urandom;
      @(posedge SYS_CLK_I);
      TX_WR_EN_I <= 1'b1; TX_WR_WORD_I <= w; TX_WR_LAST_I <= (i == n-1); TX_END_UNUSED_BYTES_I <= u;
      exp_tx.push_back({i == 0, i == n-1, (i == n-1) ? u : 5'h00, w});
    end
    @(posedge SYS_CLK_I);
    TX_WR_EN_I <= 1'b0;
  endtask

  task rx_pkt(input int n, input logic keep);
    logic [DW-1:0] w;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < DW/32; k++) w[k*32 +: 32] = $urandom;
      mac.send(w, i == n-1);
      if (keep) exp_rx.push_back({1'b0, i == n-1, (i == n-1) ? 5'h0a : 5'h00, w});
    end
    mac.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Output watcher: each result takes the oldest note of its stream
  always @(posedge SYS_CLK_I) begin
    if (MAC_TX_VALID_O && MAC_TX_READY_I)
      chk({MAC_TX_FIRST_FLAG_O, MAC_TX_LAST_FLAG_O, MAC_TX_LAST_FLAG_O ? MAC_TX_UNUSED_BYTES_O : 5'h00,
           MAC_TX_WORD_O}, exp_tx.pop_front());
    if (RX_RD_EN_I && !RX_EMPTY_O)
      chk({1'b0, RX_RD_LAST_O, RX_RD_LAST_O ? RX_RD_UNUSED_BYTES_O : 5'h00,
           RX_RD_WORD_O}, exp_rx.pop_front());
    if (PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I)
      chk({PSLVERR_O, PRDATA_O}, exp_reg.pop_front());
  end

  // Watchdog sized well above the expected run length
  initial begin
    repeat (30000) @(posedge SYS_CLK_I);
    mismatches++;
    $display("Error at %0t: timeout", $time);
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int t;
    RST_B_I = 1'b0; PSEL_I = 1'b0; PENABLE_I = 1'b0; PWRITE_I = 1'b0; PADDR_I = '0; PWDATA_I = '0;
    TX_WR_EN_I = 1'b0; TX_WR_LAST_I = 1'b0; TX_WR_WORD_I = '0; TX_END_UNUSED_BYTES_I = 5'h04;
    RX_RD_EN_I = 1'b0; slow = 1'b0;
    void'($urandom(70313));
    repeat (16) @(posedge SYS_CLK_I);
    RST_B_I <= 1'b1;
    apb(1'b0, `OMA_REG_CTRL, 32'h0, {1'b0, 32'h0000_0003});
    apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0000_0000});
    // Prompt then stalling sink, both unused codes, one-word packets too
    for (int p = 0; p < 6; p++) begin
      slow <= (p >= 3);
      tx_pkt(1 + $urandom_range(3), p[0]);
    end
    t = 0;
    while (exp_tx.size() != 0 && t < 2000) begin @(posedge SYS_CLK_I); t++; end
    repeat (4) @(posedge SYS_CLK_I);
    apb(1'b0, `OMA_REG_TX_SENT, 32'h0, {1'b0, 32'h0000_0006});
    apb(1'b1, `OMA_REG_STATUS, 32'hffff_ffff, 33'h0);
    apb(1'b0, `OMA_REG_STATUS, 32'h0, {1'b0, 32'h0000_0000});
    // Fill to 223 words, admit one more, then two packets refused
    for (int p = 0; p < 27; p++) rx_pkt(8, 1'b1);
    rx_pkt(7, 1'b1);
    rx_pkt(1, 1'b1);
    rx_pkt(2, 1'b0);
    rx_pkt(1, 1'b0);
    apb(1'b0, `OMA_REG_RX_DROP, 32'h0, {1'b0, 32'h0000_0002});
    apb(1'b0, `OMA_REG_RX_TAKEN, 32'h0, {1'b0, 32'h0000_001d});
    @(posedge SYS_CLK_I);
    RX_RD_EN_I <= 1'b1;
    t = 0;
    while (exp_rx.size() != 0 && t < 1000) begin @(posedge SYS_CLK_I); t++; end
    rx_pkt(1, 1'b1);
    repeat (4) @(posedge SYS_CLK_I);
    chk(exp_tx.size() + exp_rx.size() + exp_reg.size() + TX_FULL_O, 263'h0);
    test_done();
  end
endmodule // oma_adapter_test
